// File: bench/lue_peer.sv
// Peer unit and core traffic source facing the enable/state block.
// Assumes the bench calls its tasks; drives change at the falling edge.
module lue_peer (
  // Clock
  input wire logic sys_clk,
  // Messages and transfer status
  output logic msgRestart,
  output logic msgNmi,
  output logic msgSmi,
  output logic msgStartup,
  output logic ipiBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {msgStartup, msgSmi, msgNmi, msgRestart} = 4'h0;
    ipiBusy = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // One-cycle pulses, idle low between them
  task automatic send(input logic [3:0] kind);
    @(negedge sys_clk);
    {msgStartup, msgSmi, msgNmi, msgRestart} = kind;
    @(negedge sys_clk);
    {msgStartup, msgSmi, msgNmi, msgRestart} = 4'h0;
  endtask : send
  task automatic busy(input logic level);
    @(negedge sys_clk);
    ipiBusy = level;
  endtask : busy
endmodule : lue_peer

// File: bench/tb_top.sv
// Self-checking bench for the local interrupt unit enable/state block.
// Assumes lue_map.svh on the include path; peer model drives messages.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, sys_rst, strapBoot, msrWr, msrRd, memWr, memRd, msrAck, memHit;
  logic unitPresent, swEnabled, takeRestart, takeNmi, takeSmi, takeStartup;
  logic msgRestart, msgNmi, msgSmi, msgStartup, ipiBusy;
  logic [7:0] strapId;
  logic [31:0] msrAddr, memWdata, memRdata, idResult;
  logic [63:0] msrWdata, msrRdata;
  logic [35:0] memAddr;
  logic [5:0] lvtMasked;
  int mismatches = 0;
  int check_count = 0;
  lue_unit lue_unit_inst (.sys_clk, .sys_rst, .strapId, .strapBoot, .msrWr, .msrRd, .msrAddr,
    .msrWdata, .msrRdata, .msrAck, .memWr, .memRd, .memAddr, .memWdata, .memRdata, .memHit,
    .ipiBusy, .msgRestart, .msgNmi, .msgSmi, .msgStartup, .unitPresent, .swEnabled, .idResult,
    .takeRestart, .takeNmi, .takeSmi, .takeStartup, .lvtMasked);
  lue_peer lue_peer_inst (.sys_clk, .msgRestart, .msgNmi, .msgSmi, .msgStartup, .ipiBusy);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // Straps settle during reset; sync needs a few edges after release
  task automatic rst(input logic boot, input logic [7:0] id);
    @(negedge sys_clk);
    {sys_rst, strapBoot, strapId} = {1'b1, boot, id};
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (5) @(negedge sys_clk);
  endtask : rst
  task automatic msr(input logic wr, input logic [31:0] a, input logic [63:0] d, output logic k,
                     output logic [63:0] r);
    @(negedge sys_clk);
    {msrWr, msrRd, msrAddr, msrWdata} = {wr, !wr, a, d};
    @(negedge sys_clk);
    {msrWr, msrRd, k, r} = {2'b00, msrAck, msrRdata};
  endtask : msr
  task automatic mem(input logic wr, input logic [35:0] a, input logic [31:0] d, output logic h,
                     output logic [31:0] r);
    @(negedge sys_clk);
    {memWr, memRd, memAddr, memWdata} = {wr, !wr, a, d};
    @(negedge sys_clk);
    {memWr, memRd, h, r} = {2'b00, memHit, memRdata};
  endtask : mem
  task automatic msgs(input logic [3:0] kind, input logic [3:0] exp);
    lue_peer_inst.send(kind);
    chk("take", exp, {takeStartup, takeSmi, takeNmi, takeRestart});
  endtask : msgs
  task automatic msr_rd(input logic [63:0] exp);
    logic k;
    logic [63:0] r;
    msr(1'b0, 32'h1b, 64'h0, k, r);
    chk("base_locator", exp, r);
  endtask : msr_rd
  ////////////////////////////////////////////////////////////
  task automatic t_reset(input logic [35:0] w);
    logic h;
    logic k;
    logic [31:0] r;
    logic [63:0] q;
    logic [11:0] offs [9] = '{12'h0f0, 12'h0e0, 12'h080, 12'h0d0, 12'h300, 12'h320, 12'h380,
                              12'h3e0, 12'h020};
    logic [31:0] exps [9] = '{32'hff, 32'hffffffff, 0, 0, 0, 32'h10000, 0, 0, 32'h5a000000};
    msr_rd(64'hfee00900);
    chk("present", 1, unitPresent);
    chk("swen", 0, swEnabled);
    chk("masks", 6'h3f, lvtMasked);
    chk("id", 8'h5a, idResult[31:24]);
    for (int i = 0; i < 9; i++) begin
      mem(1'b0, w + offs[i], 0, h, r);
      chk("reg", {1'b1, exps[i]}, {h, r});
    end
    msr(1'b0, 32'h1c, 64'h0, k, q);
    chk("other_msr_ack", 0, k);
    msgs(4'hf, 4'h7);
  endtask : t_reset
  task automatic t_soft(input logic [35:0] w);
    logic h;
    logic [31:0] r;
    mem(1'b1, w + 12'h0f0, 32'h1ff, h, r);
    repeat (3) @(negedge sys_clk);
    chk("swen_on", 1, swEnabled);
    mem(1'b1, w + 12'h320, 0, h, r);
    repeat (2) @(negedge sys_clk);
    chk("unmask", 0, lvtMasked[0]);
    mem(1'b1, w + 12'h080, 32'h20, h, r);
    lue_peer_inst.busy(1'b1);
    mem(1'b1, w + 12'h0f0, 32'h0ff, h, r);
    repeat (4) @(negedge sys_clk);
    chk("swen_busy", 1, swEnabled);
    lue_peer_inst.busy(1'b0);
    repeat (4) @(negedge sys_clk);
    chk("swen_off", 0, swEnabled);
    mem(1'b0, w + 12'h080, 0, h, r);
    chk("tpr_kept", {1'b1, 32'h20}, {h, r});
    mem(1'b1, w + 12'h320, 0, h, r);
    repeat (2) @(negedge sys_clk);
    chk("masks_held", 6'h3f, lvtMasked);
    msgs(4'h7, 4'h7);
  endtask : t_soft
  task automatic t_reloc_global();
    logic h;
    logic k;
    logic [31:0] r;
    logic [63:0] q;
    msr(1'b1, 32'h1b, 64'h0000_0100_0012_38ff, k, q);
    msr_rd(64'h00123900);
    mem(1'b0, 36'h000123020, 0, h, r);
    chk("new_window", {1'b1, 32'h5a000000}, {h, r});
    mem(1'b0, 36'h0fee00020, 0, h, r);
    chk("old_window", 0, h);
    mem(1'b1, 36'h000123020, 32'h21000000, h, r);
    chk("id_rewrite", 8'h21, idResult[31:24]);
    msr(1'b1, 32'h1b, 64'h00123000, k, q);
    repeat (2) @(negedge sys_clk);
    chk("absent", 0, unitPresent);
    msr(1'b1, 32'h1b, 64'h00123800, k, q);
    msr_rd(64'h00123100);
    chk("stays_absent", 0, unitPresent);
    msgs(4'hf, 4'h0);
  endtask : t_reloc_global
  task automatic t_secondary();
    rst(1'b0, 8'h03);
    msr_rd(64'hfee00800);
    chk("id2", 8'h03, idResult[31:24]);
    msgs(4'hf, 4'hf);
  endtask : t_secondary
  ////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    {msrWr, msrRd, memWr, memRd, msrAddr, msrWdata, memAddr, memWdata} = '0;
    rst(1'b1, 8'h5a);
    t_reset(36'h0fee00000);
    t_soft(36'h0fee00000);
    t_reloc_global();
    t_secondary();
    tally_and_finish();
  end
  // Whole run is well under a thousand cycles
  initial begin
    #100us;
    mismatches++;
    tally_and_finish();
  end
endmodule : tb_top

// File: verilog/lue_map.svh
// Offsets, field positions, reset values for the local interrupt unit enable/state block.
// Assumes inclusion by the design module only.
`ifndef LUE_MAP_SVH
`define LUE_MAP_SVH
`define LUE_BASE_LOC_ADDR 32'h0000001b
`define LUE_BOOT_BIT 8
`define LUE_GEN_BIT 11
`define LUE_BASE_LO 12
`define LUE_BASE_HI 35
`define LUE_BASE_RST 24'h0fee00
`define LUE_WIN_SHIFT 12
`define LUE_SPUR_RST 32'h000000ff
`define LUE_SWEN_BIT 8
`define LUE_FMT_RST 32'hffffffff
`define LUE_MASK_BIT 16
`define LUE_LVT_RST 32'h00010000
`define LUE_FEAT_BIT 9
`define LUE_OFF_ID 12'h020
`define LUE_OFF_TPR 12'h080
`define LUE_OFF_LTR 12'h0d0
`define LUE_OFF_FMT 12'h0e0
`define LUE_OFF_SPUR 12'h0f0
`define LUE_OFF_CMD_LO 12'h300
`define LUE_OFF_LVT0 12'h320
`define LUE_OFF_LVT5 12'h370
`define LUE_OFF_INIT 12'h380
`define LUE_OFF_DIV 12'h3e0
`define LUE_ID_POS 24
`define LUE_STRAP_LATCH 2'h2
`endif

// File: verilog/lue_pkg.sv
// Types for the local interrupt unit enable/state block.
// Assumes lue_map.svh is on the include path.
package lue_pkg;
  typedef enum logic [1:0] {
    LUE_ST_ON = 2'b00,
    LUE_ST_SWOFF = 2'b01,
    LUE_ST_GLOFF = 2'b11
  } lue_mode_t;
endpackage : lue_pkg

// File: verilog/lue_unit.sv
// Enable, relocation, identity and reset-state control of a local interrupt unit.
// Assumes a core-side register port on sys_clk; strap pins are asynchronous.
`include "lue_map.svh"

module lue_unit import lue_pkg::*; #(
  parameter int ID_W = 8,
  parameter int NUM_LVT = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Straps (asynchronous)
  input wire logic [ID_W-1:0] strapId,
  input wire logic strapBoot,
  // Model-specific register port
  input wire logic msrWr,
  input wire logic msrRd,
  input wire logic [31:0] msrAddr,
  input wire logic [63:0] msrWdata,
  output logic [63:0] msrRdata,
  output logic msrAck,
  // Memory-mapped window port
  input wire logic memWr,
  input wire logic memRd,
  input wire logic [35:0] memAddr,
  input wire logic [31:0] memWdata,
  output logic [31:0] memRdata,
  output logic memHit,
  // Interprocessor traffic in progress
  input wire logic ipiBusy,
  // Incoming messages
  input wire logic msgRestart,
  input wire logic msgNmi,
  input wire logic msgSmi,
  input wire logic msgStartup,
  // Status to core
  output logic unitPresent,
  output logic swEnabled,
  output logic [31:0] idResult,
  output logic takeRestart,
  output logic takeNmi,
  output logic takeSmi,
  output logic takeStartup,
  output logic [NUM_LVT-1:0] lvtMasked
);

  typedef struct packed {
    logic [ID_W-1:0] idSync1, idSync2;
    logic bootSync1, bootSync2;
    logic [1:0] strapWait;
    logic bootFlag;
    logic globalEn;
    logic [23:0] base;
    logic [ID_W-1:0] unitId;
    logic [31:0] spur, task_priority_reg, ltr, fmt, cmdLo, initCnt, divCfg;
    logic [NUM_LVT-1:0][31:0] local_vector_table;
    lue_mode_t mode;
    logic [63:0] msrRdata;
    logic msrAck;
    logic [31:0] memRdata;
    logic memHit;
    logic unitPresent, swEnabled;
    logic [31:0] idResult;
    logic takeRestart, takeNmi, takeSmi, takeStartup;
    logic [NUM_LVT-1:0] lvtMasked;
  } lue_state_t;

  lue_state_t st, next_st;
  logic [11:0] off;
  logic inWin;
  int i;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // Software disable clears nothing, so pending state is kept
    next_st = st;
    off = memAddr[11:0];
    inWin = (memAddr[35:`LUE_WIN_SHIFT] == st.base) && st.globalEn;
    next_st.idSync1 = strapId;
    next_st.idSync2 = st.idSync1;
    next_st.bootSync1 = strapBoot;
    next_st.bootSync2 = st.bootSync1;
    // Straps need two edges through the synchroniser before the latch
    if (st.strapWait != 2'h3) begin
      next_st.strapWait = st.strapWait + 2'h1;
      if (st.strapWait == `LUE_STRAP_LATCH) begin
        next_st.unitId = st.idSync2;
        next_st.bootFlag = st.bootSync2;
      end
    end
    next_st.msrAck = 1'b0;
    next_st.msrRdata = 64'h0;
    if ((msrWr || msrRd) && msrAddr == `LUE_BASE_LOC_ADDR) begin
      next_st.msrAck = 1'b1;
      next_st.msrRdata[`LUE_BOOT_BIT] = st.bootFlag;
      next_st.msrRdata[`LUE_GEN_BIT] = st.globalEn;
      next_st.msrRdata[`LUE_BASE_HI:`LUE_BASE_LO] = st.base;
      if (msrWr) begin
        next_st.globalEn = st.globalEn & msrWdata[`LUE_GEN_BIT];
        next_st.base = msrWdata[`LUE_BASE_HI:`LUE_BASE_LO];
      end
    end
    next_st.memHit = 1'b0;
    next_st.memRdata = 32'h0;
    if ((memWr || memRd) && inWin) begin
      next_st.memHit = 1'b1;
      case (off)
        `LUE_OFF_ID: next_st.memRdata = 32'(st.unitId) << `LUE_ID_POS;
        `LUE_OFF_TPR: next_st.memRdata = st.task_priority_reg;
        `LUE_OFF_LTR: next_st.memRdata = st.ltr;
        `LUE_OFF_FMT: next_st.memRdata = st.fmt;
        `LUE_OFF_SPUR: next_st.memRdata = st.spur;
        `LUE_OFF_CMD_LO: next_st.memRdata = st.cmdLo;
        `LUE_OFF_INIT: next_st.memRdata = st.initCnt;
        `LUE_OFF_DIV: next_st.memRdata = st.divCfg;
        default: begin
          for (i = 0; i < NUM_LVT; i++) begin
            if (off == `LUE_OFF_LVT0 + 12'(i * 16)) next_st.memRdata = st.local_vector_table[i];
          end
        end
      endcase
      if (memWr) begin
        case (off)
          `LUE_OFF_ID: next_st.unitId = memWdata[`LUE_ID_POS +: ID_W];
          `LUE_OFF_TPR: next_st.task_priority_reg = memWdata;
          `LUE_OFF_LTR: next_st.ltr = memWdata;
          `LUE_OFF_FMT: next_st.fmt[31:28] = memWdata[31:28];
          `LUE_OFF_SPUR: next_st.spur[8:0] = memWdata[8:0];
          `LUE_OFF_CMD_LO: next_st.cmdLo = memWdata;
          `LUE_OFF_INIT: next_st.initCnt = memWdata;
          `LUE_OFF_DIV: next_st.divCfg = memWdata;
          default: begin
            for (i = 0; i < NUM_LVT; i++) begin
              if (off == `LUE_OFF_LVT0 + 12'(i * 16)) next_st.local_vector_table[i] = memWdata;
            end
          end
        endcase
      end
    end
    // Mode: software disable waits for in-flight interprocessor traffic; global disable does not
    case (st.mode)
      LUE_ST_ON: begin
        if (!st.globalEn) next_st.mode = LUE_ST_GLOFF;
        else if (!st.spur[`LUE_SWEN_BIT] && !ipiBusy) next_st.mode = LUE_ST_SWOFF;
      end
      LUE_ST_SWOFF: begin
        if (!st.globalEn) next_st.mode = LUE_ST_GLOFF;
        else if (st.spur[`LUE_SWEN_BIT]) next_st.mode = LUE_ST_ON;
      end
      LUE_ST_GLOFF: next_st.mode = LUE_ST_GLOFF;
      default: next_st.mode = LUE_ST_GLOFF;
    endcase
    // Masks forced while not enabled; pending state is untouched
    if (next_st.mode != LUE_ST_ON) begin
      for (i = 0; i < NUM_LVT; i++) next_st.local_vector_table[i][`LUE_MASK_BIT] = 1'b1;
    end
    for (i = 0; i < NUM_LVT; i++) next_st.lvtMasked[i] = next_st.local_vector_table[i][`LUE_MASK_BIT];
    next_st.unitPresent = next_st.globalEn;
    next_st.swEnabled = (next_st.mode == LUE_ST_ON);
    next_st.idResult = 32'(next_st.unitId) << `LUE_ID_POS;
    // Messages accepted in every mode except global disable; startup is also refused on the boot processor
    next_st.takeRestart = msgRestart && st.globalEn;
    next_st.takeNmi = msgNmi && st.globalEn;
    next_st.takeSmi = msgSmi && st.globalEn;
    next_st.takeStartup = msgStartup && st.globalEn && !st.bootFlag;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.globalEn <= 1'b1;
      st.base <= `LUE_BASE_RST;
      st.fmt <= `LUE_FMT_RST;
      st.spur <= `LUE_SPUR_RST;
      st.local_vector_table <= {NUM_LVT{`LUE_LVT_RST}};
      st.lvtMasked <= '1;
      st.unitPresent <= 1'b1;
      st.mode <= LUE_ST_SWOFF;
    end else begin
      st <= next_st;
    end
  end

  assign msrRdata = st.msrRdata;
  assign msrAck = st.msrAck;
  assign memRdata = st.memRdata;
  assign memHit = st.memHit;
  assign unitPresent = st.unitPresent;
  assign swEnabled = st.swEnabled;
  assign idResult = st.idResult;
  assign takeRestart = st.takeRestart;
  assign takeNmi = st.takeNmi;
  assign takeSmi = st.takeSmi;
  assign takeStartup = st.takeStartup;
  assign lvtMasked = st.lvtMasked;

  //////////////////////////////////////////////////////////////////////////////
  sequence s_clearGen;
    msrWr && msrAddr == `LUE_BASE_LOC_ADDR && !msrWdata[`LUE_GEN_BIT];
  endsequence
  property p_genSticky;
    @(posedge sys_clk) disable iff (sys_rst) s_clearGen |=> !st.globalEn [*8];
  endproperty
  a_genSticky: assert property (p_genSticky) else $error("global enable came back");
  property p_feature;
    @(posedge sys_clk) disable iff (sys_rst) !st.globalEn |=> !unitPresent;
  endproperty
  a_feature: assert property (p_feature) else $error("unit present while disabled");
  property p_swOn;
    @(posedge sys_clk) disable iff (sys_rst)
      st.globalEn && st.mode == LUE_ST_SWOFF && st.spur[`LUE_SWEN_BIT] |=> swEnabled;
  endproperty
  a_swOn: assert property (p_swOn) else $error("software enable not honoured");
  property p_msrAck;
    @(posedge sys_clk) disable iff (sys_rst) msrRd && msrAddr == `LUE_BASE_LOC_ADDR |=> msrAck;
  endproperty
  a_msrAck: assert property (p_msrAck) else $error("base locator not decoded");
  property p_reserved;
    @(posedge sys_clk) disable iff (sys_rst)
      msrAck |-> msrRdata[7:0] == 8'h0 && msrRdata[10:9] == 2'h0 && msrRdata[63:36] == 28'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");
  property p_rstBase;
    @(posedge sys_clk) $fell(sys_rst) |-> st.base == `LUE_BASE_RST && st.globalEn;
  endproperty
  a_rstBase: assert property (p_rstBase) else $error("reset base wrong");
  property p_masks;
    @(posedge sys_clk) disable iff (sys_rst) !swEnabled |-> lvtMasked == '1;
  endproperty
  a_masks: assert property (p_masks) else $error("mask cleared while disabled");
  property p_ipiWait;
    @(posedge sys_clk) disable iff (sys_rst) st.mode == LUE_ST_ON && ipiBusy |=> st.mode != LUE_ST_SWOFF;
  endproperty
  a_ipiWait: assert property (p_ipiWait) else $error("disabled during transfer");
  property p_startup;
    @(posedge sys_clk) disable iff (sys_rst) msgStartup && st.globalEn && !st.bootFlag |=> takeStartup;
  endproperty
  a_startup: assert property (p_startup) else $error("startup not accepted");
  property p_bootStartup;
    @(posedge sys_clk) disable iff (sys_rst) msgStartup && st.bootFlag |=> !takeStartup;
  endproperty
  a_bootStartup: assert property (p_bootStartup) else $error("startup taken on boot processor");
  property p_restart;
    @(posedge sys_clk) disable iff (sys_rst) msgRestart && st.globalEn |=> takeRestart;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not accepted");
  property p_nmi;
    @(posedge sys_clk) disable iff (sys_rst) msgNmi && st.globalEn |=> takeNmi;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nonmaskable not accepted");
  property p_smi;
    @(posedge sys_clk) disable iff (sys_rst) msgSmi && st.globalEn |=> takeSmi;
  endproperty
  a_smi: assert property (p_smi) else $error("system management not accepted");
  sequence s_swDisable;
    st.globalEn && st.mode == LUE_ST_ON && !st.spur[`LUE_SWEN_BIT] && !ipiBusy;
  endsequence
  property p_swOff;
    @(posedge sys_clk) disable iff (sys_rst) s_swDisable |=> !swEnabled && lvtMasked == '1;
  endproperty
  a_swOff: assert property (p_swOff) else $error("software disable not honoured");
  property p_window;
    @(posedge sys_clk) disable iff (sys_rst)
      (memWr || memRd) && (memAddr[35:`LUE_WIN_SHIFT] != st.base || !st.globalEn) |=> !memHit;
  endproperty
  a_window: assert property (p_window) else $error("access outside window answered");
  sequence s_strapLatch;
    st.strapWait == `LUE_STRAP_LATCH && !memWr;
  endsequence
  property p_strapId;
    @(posedge sys_clk) disable iff (sys_rst)
      s_strapLatch |=> st.unitId == $past(st.idSync2) && st.bootFlag == $past(st.bootSync2);
  endproperty
  a_strapId: assert property (p_strapId) else $error("strap values not latched");
  property p_rstState;
    @(posedge sys_clk)
      $fell(sys_rst) |-> st.fmt == `LUE_FMT_RST && st.spur == `LUE_SPUR_RST && st.task_priority_reg == 32'h0 &&
        st.ltr == 32'h0 && st.cmdLo == 32'h0 && st.initCnt == 32'h0 && st.divCfg == 32'h0 &&
        lvtMasked == '1 && !swEnabled;
  endproperty
  a_rstState: assert property (p_rstState) else $error("reset state wrong");

endmodule : lue_unit
